// ==== hw/sps_pkg.sv ====
// Package: register map, fields, timing and types of the slot power sequencer
package sps_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] BUCK_SLOT_SELECT_OFS      = 8'h0B;
	localparam logic [7:0] LDO3_LDO4_SLOT_SELECT_OFS = 8'h0D;
	localparam logic [7:0] SEQUENCE_COMMAND_STATUS_OFS    = 8'h0E;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BUCK_SLOT_LSB      = 0;
	localparam int THIRD_LDO_SLOT_LSB = 0;
	localparam int FOURTH_LDO_SLOT_LSB = 3;
	localparam int SLOT_PERIOD_LSB    = 6;
	localparam int SEQ_COMMAND_LSB    = 4;
	localparam int SEQ_ACTIVE_BIT     = 3;
	localparam int CURRENT_SLOT_LSB   = 0;

	// ----------------------------------------------------------------
	// Reset values and codes
	// ----------------------------------------------------------------
	localparam logic [7:0] SLOT_SELECT_RST = 8'h00;
	localparam logic [1:0] SLOT_PERIOD_RST = 2'h0;
	localparam logic [2:0] SLOT_NONE       = 3'h0;
	localparam logic [2:0] SLOT_FIRST      = 3'h1;
	localparam logic [2:0] SLOT_LAST       = 3'h7;
	localparam logic [1:0] CMD_POWER_UP    = 2'h1;
	localparam logic [1:0] CMD_SHUTDOWN    = 2'h2;

	// ----------------------------------------------------------------
	// Timing: slot period is (select + 1) units of 500 us
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 200;
	localparam int SLOT_UNIT_US  = 500;
	localparam int SLOT_UNIT_CYC = SLOT_UNIT_US * CLK_MHZ;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SPS_IDLE = 2'b00,
		SPS_UP   = 2'b01,
		SPS_DOWN = 2'b10
	} sps_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sps_reg_req_t;

	typedef struct packed {
		logic buck;
		logic third_ldo;
		logic fourth_ldo;
	} sps_rails_t;

endpackage

// ==== hw/sps_slot_timer.sv ====
// Slot timer: one-cycle pulse at the end of each sequencer slot
`timescale 1ns/100ps
module sps_slot_timer #(
	parameter int UNIT_CYCLES = sps_pkg::SLOT_UNIT_CYC
) (
	// Clock and reset
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	// Control
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [1:0] period_sel,
	// Status
	output logic            slot_end
);
	localparam int CW = $clog2(UNIT_CYCLES + 1);
	localparam logic [CW-1:0] UNIT_LAST = CW'(UNIT_CYCLES - 1);

	logic [CW-1:0] unit_cnt_q;
	logic [CW-1:0] unit_cnt_d;
	logic [1:0]    unit_idx_q;
	logic [1:0]    unit_idx_d;
	logic          slot_end_q;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// Restart clears both counters so every slot gets its full period
	wire unit_done = run && !restart && (unit_cnt_q == UNIT_LAST);
	wire slot_done = unit_done && (unit_idx_q == period_sel);

	assign unit_cnt_d = (!run || restart || unit_done) ? '0 : unit_cnt_q + CW'(1);
	assign unit_idx_d = (!run || restart || slot_done) ? 2'h0
		: (unit_done ? unit_idx_q + 2'h1 : unit_idx_q);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			unit_cnt_q <= '0;
			unit_idx_q <= 2'h0;
			slot_end_q <= 1'b0;
		end else begin
			unit_cnt_q <= unit_cnt_d;
			unit_idx_q <= unit_idx_d;
			slot_end_q <= slot_done;
		end
	end

	assign slot_end = slot_end_q;

endmodule // sps_slot_timer

// ==== hw/sps_sequencer.sv ====
// Slot power sequencer: slot registers, sequence engine and rail enables
// ----------------------------------------------------------------
// Summary of operation
// - Fourth LDO field bits 5:3; zero means direct
// - Fourth LDO nonzero field picks power-up slot
// - Third LDO field bits 2:0; zero means direct
// - Third LDO nonzero field picks power-up slot
// - Seven slots, period 500us to 2ms
// - Command 01 starts power-up sequence
// - Command 10 shutdown; 11 and 00 ignored
// - Command field self-clears, reads 00
// - Active until slot 7 or 1 ends
// - Unused slots still run full period
// - Slot counter reads 000 when idle
// - Slot counter shows executing slot 1-7
// - Buck slot field, same encoding
// ----------------------------------------------------------------
`timescale 1ns/100ps
module sps_sequencer #(
	parameter int UNIT_CYCLES = sps_pkg::SLOT_UNIT_CYC
) (
	// Clock and reset
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	// Register access from the serial front end
	input  wire sps_pkg::sps_reg_req_t reg_req,
	output logic [7:0]                reg_rdata,
	// Direct enable bits held elsewhere
	input  wire logic                 buck_direct_enable,
	input  wire logic                 third_ldo_direct_enable,
	input  wire logic                 fourth_ldo_direct_enable,
	// Rail enables
	output sps_pkg::sps_rails_t       rail_enable
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	sps_pkg::sps_state_t state_q;
	sps_pkg::sps_state_t state_d;
	logic [2:0]          buck_slot_field_q;
	logic [2:0]          third_ldo_slot_field_q;
	logic [2:0]          fourth_ldo_slot_field_q;
	logic [1:0]          slot_period_select_q;
	logic [2:0]          current_slot_q;
	logic [2:0]          current_slot_d;
	sps_pkg::sps_rails_t sequence_active_q;
	sps_pkg::sps_rails_t sequence_active_d;
	sps_pkg::sps_rails_t rail_d;
	sps_pkg::sps_rails_t rail_q;
	logic [7:0]          rdata_q;
	logic [7:0]          rdata_d;
	logic                slot_end;

	// Sequenced state of one rail: on in its slot going up, off in it going down
	function automatic logic rail_step(input logic cur, input logic [2:0] field,
		input sps_pkg::sps_state_t st, input logic [2:0] slot);
		logic hit;
		hit = (field != sps_pkg::SLOT_NONE) && (field == slot);
		if (hit && st == sps_pkg::SPS_UP)
			rail_step = 1'b1;
		else if (hit && st == sps_pkg::SPS_DOWN)
			rail_step = 1'b0;
		else
			rail_step = cur;
	endfunction

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	wire wr_buck = reg_req.wr && (reg_req.addr == sps_pkg::BUCK_SLOT_SELECT_OFS);
	wire wr_ldo  = reg_req.wr && (reg_req.addr == sps_pkg::LDO3_LDO4_SLOT_SELECT_OFS);
	wire wr_seq  = reg_req.wr && (reg_req.addr == sps_pkg::SEQUENCE_COMMAND_STATUS_OFS);
	wire [1:0] cmd = reg_req.wdata[sps_pkg::SEQ_COMMAND_LSB +: 2];
	wire idle = (state_q == sps_pkg::SPS_IDLE);
	// A command while a sequence runs is dropped; restarting mid-walk would
	// leave rails in an order neither sequence promises
	wire start_up   = wr_seq && idle && (cmd == sps_pkg::CMD_POWER_UP);
	wire start_down = wr_seq && idle && (cmd == sps_pkg::CMD_SHUTDOWN);
	wire active = !idle;

	// Command field never stored, so it reads 00
	wire [7:0] status_word = {slot_period_select_q, 2'b00, active, current_slot_q};

	// Unmapped offsets read zero so a stray read is harmless
	always_comb begin
		case (reg_req.addr)
			sps_pkg::BUCK_SLOT_SELECT_OFS:
				rdata_d = {5'h00, buck_slot_field_q};
			sps_pkg::LDO3_LDO4_SLOT_SELECT_OFS:
				rdata_d = {2'h0, fourth_ldo_slot_field_q, third_ldo_slot_field_q};
			sps_pkg::SEQUENCE_COMMAND_STATUS_OFS:
				rdata_d = status_word;
			default:
				rdata_d = 8'h00;
		endcase
	end

	// ----------------------------------------------------------------
	// Sequence engine
	// ----------------------------------------------------------------
	always_comb begin
		state_d        = state_q;
		current_slot_d = current_slot_q;
		case (state_q)
			sps_pkg::SPS_IDLE: begin
				if (start_up) begin
					state_d        = sps_pkg::SPS_UP;
					current_slot_d = sps_pkg::SLOT_FIRST;
				end else if (start_down) begin
					state_d        = sps_pkg::SPS_DOWN;
					current_slot_d = sps_pkg::SLOT_LAST;
				end
			end
			sps_pkg::SPS_UP: begin
				// Every slot runs out its period, used or not
				if (slot_end && current_slot_q == sps_pkg::SLOT_LAST) begin
					state_d        = sps_pkg::SPS_IDLE;
					current_slot_d = sps_pkg::SLOT_NONE;
				end else if (slot_end) begin
					current_slot_d = current_slot_q + 3'h1;
				end
			end
			sps_pkg::SPS_DOWN: begin
				if (slot_end && current_slot_q == sps_pkg::SLOT_FIRST) begin
					state_d        = sps_pkg::SPS_IDLE;
					current_slot_d = sps_pkg::SLOT_NONE;
				end else if (slot_end) begin
					current_slot_d = current_slot_q - 3'h1;
				end
			end
			default: begin
				state_d        = sps_pkg::SPS_IDLE;
				current_slot_d = sps_pkg::SLOT_NONE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Slot timer
	// ----------------------------------------------------------------
	// Slot timer pulses at the end of each slot, one slot period at the selected rate
	sps_slot_timer #(
		.UNIT_CYCLES (UNIT_CYCLES)
	) u_slot_timer (
		.clk_sys    (clk_sys),
		.sys_rst    (sys_rst),
		.run        (active),
		.restart    (start_up || start_down),
		.period_sel (slot_period_select_q),
		.slot_end   (slot_end)
	);

	// ----------------------------------------------------------------
	// Rail control
	// ----------------------------------------------------------------
	assign sequence_active_d.buck = rail_step(sequence_active_q.buck, buck_slot_field_q,
		state_q, current_slot_q);
	assign sequence_active_d.third_ldo = rail_step(sequence_active_q.third_ldo, third_ldo_slot_field_q,
		state_q, current_slot_q);
	assign sequence_active_d.fourth_ldo = rail_step(sequence_active_q.fourth_ldo, fourth_ldo_slot_field_q,
		state_q, current_slot_q);

	// Zero field hands the rail back to its direct enable
	assign rail_d.buck = (buck_slot_field_q == sps_pkg::SLOT_NONE)
		? buck_direct_enable : sequence_active_q.buck;
	assign rail_d.third_ldo = (third_ldo_slot_field_q == sps_pkg::SLOT_NONE)
		? third_ldo_direct_enable : sequence_active_q.third_ldo;
	assign rail_d.fourth_ldo = (fourth_ldo_slot_field_q == sps_pkg::SLOT_NONE)
		? fourth_ldo_direct_enable : sequence_active_q.fourth_ldo;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			buck_slot_field_q       <= sps_pkg::SLOT_NONE;
			third_ldo_slot_field_q  <= sps_pkg::SLOT_NONE;
			fourth_ldo_slot_field_q <= sps_pkg::SLOT_NONE;
		end else begin
			if (wr_buck)
				buck_slot_field_q <= reg_req.wdata[sps_pkg::BUCK_SLOT_LSB +: 3];
			if (wr_ldo) begin
				third_ldo_slot_field_q  <= reg_req.wdata[sps_pkg::THIRD_LDO_SLOT_LSB +: 3];
				fourth_ldo_slot_field_q <= reg_req.wdata[sps_pkg::FOURTH_LDO_SLOT_LSB +: 3];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			slot_period_select_q <= sps_pkg::SLOT_PERIOD_RST;
			state_q              <= sps_pkg::SPS_IDLE;
			current_slot_q       <= sps_pkg::SLOT_NONE;
		end else begin
			if (wr_seq)
				slot_period_select_q <= reg_req.wdata[sps_pkg::SLOT_PERIOD_LSB +: 2];
			state_q        <= state_d;
			current_slot_q <= current_slot_d;
		end
	end

	// Rails lag the slot by two edges; clean registered pins beat speed
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sequence_active_q <= '0;
			rail_q   <= '0;
			rdata_q  <= 8'h00;
		end else begin
			sequence_active_q <= sequence_active_d;
			rail_q   <= rail_d;
			if (reg_req.rd)
				rdata_q <= rdata_d;
		end
	end

	assign reg_rdata   = rdata_q;
	assign rail_enable = rail_q;

endmodule // sps_sequencer

// ==== sim/sps_host.sv ====
// Host model: register master on the sequencer access port
`timescale 1ns/100ps
module sps_host (
	// Clock
	input  wire logic            clk_sys,
	// Register access
	output sps_pkg::sps_reg_req_t reg_req,
	input  wire logic [7:0]      reg_rdata
);
	initial reg_req = '0;
	// One access: strobe for one edge, then inverted address and data so
	// a stale value is never mistaken for a live one
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(negedge clk_sys);
		reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk_sys);
		q = reg_rdata;
		reg_req = '{wr: 1'h0, rd: 1'h0, addr: ~a, wdata: ~d};
	endtask
endmodule // sps_host

// ==== sim/sps_properties.sv ====
// Checker: port-level properties of the slot power sequencer
`timescale 1ns/100ps
module sps_properties (
	// Clock and reset
	input wire logic                  clk_sys,
	input wire logic                  sys_rst,
	// Register access
	input wire sps_pkg::sps_reg_req_t reg_req,
	input wire logic [7:0]            reg_rdata,
	// Rails
	input wire logic                  buck_direct_enable,
	input wire logic                  third_ldo_direct_enable,
	input wire logic                  fourth_ldo_direct_enable,
	input wire sps_pkg::sps_rails_t   rail_enable
);
	logic [7:0] ls_q;
	logic [7:0] bs_q;
	wire logic  wr_cs = reg_req.wr && reg_req.addr == sps_pkg::SEQUENCE_COMMAND_STATUS_OFS;
	wire logic  rd_cs = reg_req.rd && reg_req.addr == sps_pkg::SEQUENCE_COMMAND_STATUS_OFS;
	// Shadow of slot fields, rebuilt from observed writes
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ls_q <= 8'h00;
			bs_q <= 8'h00;
		end else if (reg_req.wr) begin
			if (reg_req.addr == sps_pkg::LDO3_LDO4_SLOT_SELECT_OFS) ls_q <= reg_req.wdata;
			if (reg_req.addr == sps_pkg::BUCK_SLOT_SELECT_OFS) bs_q <= reg_req.wdata;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	a_cmd_reads_zero: assert property (rd_cs |=> reg_rdata[5:4] == 2'h0)
		else $error("command field read back nonzero");
	a_slot_vs_active: assert property (rd_cs |=> reg_rdata[3] == (reg_rdata[2:0] != 3'h0))
		else $error("slot count disagrees with active flag");
	a_rdata_holds: assert property (!reg_req.rd |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	a_period_back: assert property (wr_cs ##2 rd_cs |=>
		reg_rdata[7:6] == $past(reg_req.wdata[7:6], 3)) else $error("period select lost");
	a_start_active: assert property (wr_cs && reg_req.wdata[5:4] == 2'h1 ##2 rd_cs
		|=> reg_rdata[3]) else $error("power-up did not start");
	a_third_direct: assert property (!$past(sys_rst) && $past(ls_q[2:0]) == 3'h0
		|-> rail_enable.third_ldo == $past(third_ldo_direct_enable)) else $error("third rail not direct");
	a_fourth_direct: assert property (!$past(sys_rst) && $past(ls_q[5:3]) == 3'h0
		|-> rail_enable.fourth_ldo == $past(fourth_ldo_direct_enable)) else $error("fourth rail not direct");
	a_buck_direct: assert property (!$past(sys_rst) && $past(bs_q[2:0]) == 3'h0
		|-> rail_enable.buck == $past(buck_direct_enable)) else $error("buck rail not direct");
endmodule // sps_properties

// ==== sim/testbench.sv ====
// Testbench: register-level tests of the slot power sequencer
`timescale 1ns/100ps
module testbench;
	localparam int         UNIT = 20;
	localparam logic [7:0] LS   = sps_pkg::LDO3_LDO4_SLOT_SELECT_OFS;
	localparam logic [7:0] BS   = sps_pkg::BUCK_SLOT_SELECT_OFS;
	localparam logic [7:0] CS   = sps_pkg::SEQUENCE_COMMAND_STATUS_OFS;
	logic                  clk_sys;
	logic                  sys_rst;
	sps_pkg::sps_reg_req_t reg_req;
	logic [7:0]            reg_rdata;
	logic [2:0]            dir_en;
	sps_pkg::sps_rails_t   rail_enable;
	logic [7:0]            q;
	int                    bad_count;
	int                    cmp_count;
	sps_sequencer #(.UNIT_CYCLES(UNIT)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .buck_direct_enable(dir_en[2]),
		.third_ldo_direct_enable(dir_en[1]), .fourth_ldo_direct_enable(dir_en[0]),
		.rail_enable(rail_enable));
	sps_host host_u (.clk_sys(clk_sys), .reg_req(reg_req), .reg_rdata(reg_rdata));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host_u.xfer(1'h1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
		host_u.xfer(1'h0, a, 8'h00, q);
		chk(nm, e, q);
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Fields fixed by the bench: buck 1, third 7, fourth 4
	function automatic logic [2:0] exp_rails(input int k, input bit up);
		return up ? {k >= 1, k >= 7, k >= 4} : {k > 1, k > 7, k > 4};
	endfunction
	// Samples mid-slot so the two-cycle rail lag never lands on a check
	task automatic run_seq(input logic [1:0] per, input logic [1:0] cmd);
		int len;
		int k;
		bit up;
		len = (per + 1) * UNIT;
		up = (cmd == sps_pkg::CMD_POWER_UP);
		wr(CS, {per, cmd, 4'h0});
		rd(CS, {per, 3'h1, up ? 3'h1 : 3'h7}, "first slot");
		// Opposite command mid-walk must be dropped
		wr(CS, {per, up ? sps_pkg::CMD_SHUTDOWN : sps_pkg::CMD_POWER_UP, 4'h0});
		repeat (len / 2 - 5) @(negedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			k = up ? i + 1 : 7 - i;
			rd(CS, (k % 8 == 0) ? {per, 6'h00} : {per, 3'h1, 3'(k)}, "status");
			chk("rails", {5'h00, exp_rails(k, up)}, {5'h00, rail_enable});
			repeat (len - 2) @(negedge clk_sys);
		end
		$display("test sequence %0d period %0d done", cmd, per);
	endtask
	initial begin
		clk_sys = 1'h0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	// Hang guard well beyond the longest run
	initial begin
		#50000;
		bad_count++;
		conclude();
	end
	initial begin
		sys_rst = 1'h1;
		dir_en = 3'h0;
		bad_count = 0;
		cmp_count = 0;
		repeat (20) @(negedge clk_sys);
		sys_rst = 1'h0;
		rd(LS, 8'h00, "ldo slot reset");
		rd(BS, 8'h00, "buck slot reset");
		rd(CS, 8'h00, "status reset");
		wr(8'h40, 8'hFF);
		rd(8'h40, 8'h00, "unmapped");
		$display("test reset done");
		for (int p = 0; p < 8; p++) begin
			dir_en = 3'(p);
			repeat (3) @(negedge clk_sys);
			chk("direct rails", {5'h00, 3'(p)}, {5'h00, rail_enable});
		end
		dir_en = 3'h0;
		$display("test direct done");
		wr(LS, 8'hFF);
		rd(LS, 8'h3F, "ldo slot fields");
		wr(BS, 8'hFF);
		rd(BS, 8'h07, "buck slot field");
		wr(LS, 8'h27);
		wr(BS, 8'h01);
		wr(CS, 8'h30);
		rd(CS, 8'h00, "ignored command");
		wr(CS, 8'h00);
		rd(CS, 8'h00, "null command");
		$display("test fields done");
		run_seq(2'h0, sps_pkg::CMD_POWER_UP);
		run_seq(2'h1, sps_pkg::CMD_SHUTDOWN);
		run_seq(2'h2, sps_pkg::CMD_POWER_UP);
		run_seq(2'h3, sps_pkg::CMD_SHUTDOWN);
		// Reset in mid-walk must drop status, fields and rails
		wr(CS, {2'h0, sps_pkg::CMD_POWER_UP, 4'h0});
		repeat (5 * UNIT / 2) @(negedge clk_sys);
		chk("rails mid walk", 8'h04, {5'h00, rail_enable});
		sys_rst = 1'h1;
		repeat (2) @(negedge clk_sys);
		sys_rst = 1'h0;
		rd(CS, 8'h00, "status after reset");
		chk("rails after reset", 8'h00, {5'h00, rail_enable});
		rd(LS, 8'h00, "ldo slot after reset");
		$display("test mid reset done");
		conclude();
	end
endmodule // testbench
bind sps_sequencer sps_properties chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .buck_direct_enable(buck_direct_enable),
	.third_ldo_direct_enable(third_ldo_direct_enable),
	.fourth_ldo_direct_enable(fourth_ldo_direct_enable), .rail_enable(rail_enable));
